/* logic/uocs_params.svh */
// Register offsets, field positions, token PIDs and timing counts of the USB control block.
`ifndef UOCS_PARAMS_SVH
`define UOCS_PARAMS_SVH

`define UOCS_IDX_STATUS 4'h0
`define UOCS_IDX_CONTROL 4'h1
`define UOCS_IDX_ADDRESS 4'h2
`define UOCS_IDX_FRAME_LOW 4'h3
`define UOCS_IDX_FRAME_HIGH 4'h4
`define UOCS_IDX_TOKEN 4'h5
`define UOCS_IDX_THRESHOLD 4'h6
`define UOCS_IDX_BDT_PAGE1 4'h7
`define UOCS_IDX_EVENTS 4'h8

`define UOCS_CON_J 7
`define UOCS_CON_SE0 6
`define UOCS_CON_HOLD 5
`define UOCS_CON_RESET 4
`define UOCS_CON_HOST 3
`define UOCS_CON_RESUME 2
`define UOCS_CON_PPCLR 1
`define UOCS_CON_ON 0
`define UOCS_ADDR_LS 7
`define UOCS_EVT_DONE 3
`define UOCS_EVT_EOF 1

`define UOCS_PID_OUT 4'h1
`define UOCS_PID_IN 4'h9
`define UOCS_PID_SETUP 4'hD

`define UOCS_QUEUE_DEPTH 4
`define UOCS_CLK_HZ 40000000
`define UOCS_FRAME_US 1000
`define UOCS_FRAME_CYCLES (`UOCS_CLK_HZ / 1000000 * `UOCS_FRAME_US)

`endif

/* logic/uocs_pkg.sv */
// Types shared by the USB control block.
package uocs_pkg;
    typedef struct packed {
        logic [3:0] endpoint;
        logic tx;
        logic odd;
    } uocs_xact_t;

    typedef struct packed {
        logic [3:0] pid;
        logic [3:0] endpoint;
    } uocs_token_t;

    typedef struct packed {
        logic [6:0] address;
        logic low_speed;
        uocs_token_t token;
    } uocs_launch_t;
endpackage

/* logic/uocs_regs.sv */
// Control and status registers of the USB OTG controller with Avalon-MM access.
`timescale 1ns/10ps
`default_nettype none
`include "uocs_params.svh"

module uocs_regs #(
    parameter int FRAME_CYCLES = `UOCS_FRAME_CYCLES,
    parameter int QUEUE_DEPTH = `UOCS_QUEUE_DEPTH
) (
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    input wire logic [3:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic live_j_line_i,
    input wire logic live_se0_i,
    input wire logic xact_done_i,
    input wire uocs_pkg::uocs_xact_t xact_status_i,
    input wire logic setup_rx_i,
    input wire logic sof_rx_i,
    input wire logic [10:0] sof_frame_i,
    input wire logic link_active_i,
    output logic bus_reset_drive_o,
    output logic resume_drive_o,
    output logic resume_eop_o,
    output logic pingpong_pointer_clear_o,
    output logic module_on_o,
    output logic host_logic_reset_o,
    output logic packet_hold_o,
    output logic token_start_o,
    output uocs_pkg::uocs_launch_t token_launch_o,
    output logic frame_start_send_o,
    output logic eof_error_o,
    output logic [7:0] frame_start_threshold_o,
    output logic [7:0] descriptor_table_base_o
);

    // ************************************************************
    // Bus slave
    // ************************************************************
    logic wr_fire;
    logic rd_fire;
    logic lane0;
    logic [7:0] wbyte;

    assign wr_fire = avs_write_i && !avs_waitrequest_o;
    assign rd_fire = avs_read_i && !avs_waitrequest_o;
    assign lane0 = avs_byteenable_i[0];
    assign wbyte = avs_writedata_i[7:0];

    function automatic logic wr_hit(input logic [3:0] idx);
        wr_hit = wr_fire && lane0 && (avs_address_i == idx);
    endfunction

    // Each access waits one cycle so that read data come from a flop.
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            avs_waitrequest_o <= 1'b1;
        end else if ((avs_read_i || avs_write_i) && avs_waitrequest_o) begin
            avs_waitrequest_o <= 1'b0;
        end else begin
            avs_waitrequest_o <= 1'b1;
        end
    end

    // ************************************************************
    // Control register
    // ************************************************************
    logic [7:0] control;
    logic host_en;
    logic token_busy;
    logic packet_hold;

    assign host_en = control[`UOCS_CON_HOST];

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            control <= 8'h00;
        end else if (wr_hit(`UOCS_IDX_CONTROL)) begin
            control <= {2'b00, 1'b0, wbyte[4:0]};
        end
    end

    // A write of the same host enable value leaves the host logic alone.
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            host_logic_reset_o <= 1'b0;
        end else begin
            host_logic_reset_o <= wr_hit(`UOCS_IDX_CONTROL)
                && (wbyte[`UOCS_CON_HOST] != host_en);
        end
    end

    // Software may only clear the hold; the SETUP event wins a same-cycle clear.
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            packet_hold <= 1'b0;
        end else if (!host_en && setup_rx_i) begin
            packet_hold <= 1'b1;
        end else if (wr_hit(`UOCS_IDX_CONTROL) && !host_en && !wbyte[`UOCS_CON_HOLD]) begin
            packet_hold <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            bus_reset_drive_o <= 1'b0;
            resume_drive_o <= 1'b0;
            pingpong_pointer_clear_o <= 1'b0;
            module_on_o <= 1'b0;
            packet_hold_o <= 1'b0;
        end else begin
            bus_reset_drive_o <= host_en && control[`UOCS_CON_RESET];
            resume_drive_o <= control[`UOCS_CON_RESUME];
            pingpong_pointer_clear_o <= control[`UOCS_CON_PPCLR];
            module_on_o <= !host_en && control[`UOCS_CON_ON];
            packet_hold_o <= packet_hold;
        end
    end

    // The low-speed end-of-packet follows the drop of resume in host mode only.
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            resume_eop_o <= 1'b0;
        end else begin
            resume_eop_o <= host_en && resume_drive_o && !control[`UOCS_CON_RESUME];
        end
    end

    // ************************************************************
    // Address, threshold and descriptor page
    // ************************************************************
    logic [7:0] device_address;
    logic [7:0] frame_start_threshold;
    logic [7:0] descriptor_page;

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            device_address <= 8'h00;
        end else if (wr_hit(`UOCS_IDX_ADDRESS)) begin
            device_address <= wbyte;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            frame_start_threshold <= 8'h00;
        end else if (wr_hit(`UOCS_IDX_THRESHOLD)) begin
            frame_start_threshold <= wbyte;
        end
    end

    // Bit 0 is unimplemented so the table stays 512-byte aligned.
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            descriptor_page <= 8'h00;
        end else if (wr_hit(`UOCS_IDX_BDT_PAGE1)) begin
            descriptor_page <= {wbyte[7:1], 1'b0};
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            frame_start_threshold_o <= 8'h00;
            descriptor_table_base_o <= 8'h00;
        end else begin
            frame_start_threshold_o <= frame_start_threshold;
            descriptor_table_base_o <= descriptor_page;
        end
    end

    // ************************************************************
    // Frame number capture
    // ************************************************************
    logic [10:0] frame_number;

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            frame_number <= 11'h000;
        end else if (sof_rx_i) begin
            frame_number <= sof_frame_i;
        end
    end

    // ************************************************************
    // Token command
    // ************************************************************
    uocs_pkg::uocs_token_t token_cmd;
    logic token_ok;

    function automatic logic pid_valid(input logic [3:0] pid);
        pid_valid = (pid == `UOCS_PID_OUT) || (pid == `UOCS_PID_IN)
            || (pid == `UOCS_PID_SETUP);
    endfunction

    // Reserved types and writes while busy are stored but never launched.
    assign token_ok = wr_hit(`UOCS_IDX_TOKEN) && host_en && !token_busy
        && pid_valid(wbyte[7:4]);

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            token_cmd <= '0;
        end else if (wr_hit(`UOCS_IDX_TOKEN)) begin
            token_cmd <= wbyte;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            token_start_o <= 1'b0;
            token_launch_o <= '0;
        end else begin
            token_start_o <= token_ok;
            if (token_ok) begin
                token_launch_o.address <= device_address[6:0];
                token_launch_o.low_speed <= device_address[`UOCS_ADDR_LS];
                token_launch_o.token <= wbyte;
            end
        end
    end

    // Busy ends with the transaction or with any host enable change.
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            token_busy <= 1'b0;
        end else if (token_ok) begin
            token_busy <= 1'b1;
        end else if (xact_done_i || host_logic_reset_o) begin
            token_busy <= 1'b0;
        end
    end

    // ************************************************************
    // Frame timer
    // ************************************************************
    logic [31:0] frame_cnt;
    logic frame_zero;

    assign frame_zero = (frame_cnt == 32'h0000_0000);

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            frame_cnt <= 32'h0000_0000;
        end else if (!host_en || host_logic_reset_o) begin
            frame_cnt <= 32'(FRAME_CYCLES - 1);
        end else if (frame_zero) begin
            frame_cnt <= 32'(FRAME_CYCLES - 1);
        end else begin
            frame_cnt <= frame_cnt - 32'h0000_0001;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            frame_start_send_o <= 1'b0;
            eof_error_o <= 1'b0;
        end else begin
            frame_start_send_o <= host_en && frame_zero && control[`UOCS_CON_ON];
            eof_error_o <= host_en && frame_zero && link_active_i;
        end
    end

    // ************************************************************
    // Status queue
    // ************************************************************
    uocs_pkg::uocs_xact_t queue [QUEUE_DEPTH];
    logic [1:0] wr_ptr;
    logic [1:0] rd_ptr;
    logic [2:0] count;
    logic push;
    logic pop;
    logic eof_flag;

    // A full queue drops the newest entry rather than overwrite the head.
    assign push = xact_done_i && (count != 3'(QUEUE_DEPTH));
    assign pop = wr_hit(`UOCS_IDX_EVENTS) && wbyte[`UOCS_EVT_DONE]
        && (count != 3'h0);

    always_ff @(posedge clk_sys_i) begin
        if (push) begin
            queue[wr_ptr] <= xact_status_i;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wr_ptr <= 2'h0;
            rd_ptr <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 2'h1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 2'h1;
            end
        end
    end

    // A push in the same cycle as a pop keeps the flag set.
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            count <= 3'h0;
        end else if (push && !pop) begin
            count <= count + 3'h1;
        end else if (pop && !push) begin
            count <= count - 3'h1;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            eof_flag <= 1'b0;
        end else if (eof_error_o) begin
            eof_flag <= 1'b1;
        end else if (wr_hit(`UOCS_IDX_EVENTS) && wbyte[`UOCS_EVT_EOF]) begin
            eof_flag <= 1'b0;
        end
    end

    // ************************************************************
    // Read data
    // ************************************************************
    logic [7:0] rbyte;
    uocs_pkg::uocs_xact_t head;

    assign head = queue[rd_ptr];

    always_comb begin
        rbyte = 8'h00;
        unique case (avs_address_i)
            `UOCS_IDX_STATUS: begin
                if (count != 3'h0) begin
                    rbyte = {head, 2'b00};
                end
            end
            `UOCS_IDX_CONTROL: begin
                rbyte = control;
                rbyte[`UOCS_CON_J] = live_j_line_i;
                rbyte[`UOCS_CON_SE0] = live_se0_i;
                rbyte[`UOCS_CON_HOLD] = host_en ? token_busy : packet_hold;
            end
            `UOCS_IDX_ADDRESS: rbyte = device_address;
            `UOCS_IDX_FRAME_LOW: rbyte = frame_number[7:0];
            `UOCS_IDX_FRAME_HIGH: rbyte = {5'b00000, frame_number[10:8]};
            `UOCS_IDX_TOKEN: rbyte = token_cmd;
            `UOCS_IDX_THRESHOLD: rbyte = frame_start_threshold;
            `UOCS_IDX_BDT_PAGE1: rbyte = descriptor_page;
            `UOCS_IDX_EVENTS: begin
                rbyte[`UOCS_EVT_DONE] = (count != 3'h0);
                rbyte[`UOCS_EVT_EOF] = eof_flag;
            end
            default: rbyte = 8'h00;
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            avs_readdata_o <= 32'h0000_0000;
        end else if ((avs_read_i || avs_write_i) && avs_waitrequest_o) begin
            avs_readdata_o <= {24'h000000, rbyte};
        end
    end

endmodule // uocs_regs
`default_nettype wire

/* testbench/uocs_regs_sva.sv */
// Concurrent checks on the ports of the USB control register block.
`timescale 1ns/10ps
`default_nettype none
module uocs_regs_chk #(
    parameter int FRAME_CYCLES = 40000,
    parameter int QUEUE_DEPTH = 4
) (
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    input wire logic [3:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    input wire logic avs_waitrequest_o,
    input wire logic link_active_i,
    input wire logic bus_reset_drive_o,
    input wire logic resume_drive_o,
    input wire logic resume_eop_o,
    input wire logic module_on_o,
    input wire logic host_logic_reset_o,
    input wire logic token_start_o,
    input wire logic frame_start_send_o,
    input wire logic eof_error_o
);
    // ****************************************
    // Helpers and properties
    // ****************************************
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);
    logic wr_take;
    logic ctl_take;
    logic tok_take;
    logic [31:0] gap;
    logic armed;
    assign wr_take = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
    assign ctl_take = wr_take && avs_address_i == 4'h1;
    assign tok_take = wr_take && avs_address_i == 4'h5;
    // Spacing is judged only between pulses with no control write between them.
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            gap <= 32'h0;
            armed <= 1'b0;
        end else begin
            gap <= frame_start_send_o ? 32'h0 : gap + 32'h1;
            armed <= (armed || frame_start_send_o) && !ctl_take;
        end
    end
    property p_wait_answer;
        (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o;
    endproperty
    a_wait_answer: assert property (p_wait_answer) else $error("waitrequest stuck");
    property p_reset_drive;
        ctl_take && avs_writedata_i[4] && avs_writedata_i[3] |-> ##[1:2] bus_reset_drive_o;
    endproperty
    a_reset_drive: assert property (p_reset_drive) else $error("bus reset not driven");
    property p_module_on;
        ctl_take && avs_writedata_i[0] && !avs_writedata_i[3] |-> ##[1:2] module_on_o;
    endproperty
    a_module_on: assert property (p_module_on) else $error("module not enabled");
    property p_host_rst;
        host_logic_reset_o |-> $past(ctl_take) || $past(ctl_take, 2);
    endproperty
    a_host_rst: assert property (p_host_rst) else $error("stray host reset");
    property p_tok_cause;
        token_start_o |-> ($past(tok_take) || $past(tok_take, 2)) ##1 !token_start_o;
    endproperty
    a_tok_cause: assert property (p_tok_cause) else $error("stray token launch");
    property p_sof_gap;
        frame_start_send_o && armed |-> gap == FRAME_CYCLES - 1;
    endproperty
    a_sof_gap: assert property (p_sof_gap) else $error("frame start spacing wrong");
    property p_eof;
        eof_error_o |-> $past(link_active_i) || link_active_i;
    endproperty
    a_eof: assert property (p_eof) else $error("frame end error while idle");
    property p_eop;
        resume_eop_o |-> !resume_drive_o && ($past(resume_drive_o) || $past(resume_drive_o, 2));
    endproperty
    a_eop: assert property (p_eop) else $error("end of packet not after resume");
endmodule // uocs_regs_chk
bind uocs_regs uocs_regs_chk #(.FRAME_CYCLES(FRAME_CYCLES), .QUEUE_DEPTH(QUEUE_DEPTH)) i_chk (.*);
`default_nettype wire

/* testbench/uocs_link_model.sv */
// Behavioural model of the USB link side facing the control register block.
`timescale 1ns/10ps
`default_nettype none
module uocs_link_model (
    input wire logic clk_sys_i,
    input wire logic token_start_i,
    input wire uocs_pkg::uocs_launch_t launch_i,
    output logic live_j_o,
    output logic live_se0_o,
    output logic done_o,
    output var uocs_pkg::uocs_xact_t status_o,
    output logic setup_o,
    output logic sof_o,
    output logic [10:0] frame_o,
    output logic active_o
);
    // ****************************************
    // Link events
    // ****************************************
    int answer_delay = 8;
    logic odd_bank = 1'b0;
    initial begin
        {live_j_o, live_se0_o, done_o, setup_o, sof_o, active_o} = 6'h00;
        status_o = 6'h00;
        frame_o = 11'h000;
    end
    // Released fields show the inverse, so a stale sample cannot pass.
    task automatic send_done(input logic [3:0] ep, input logic tx, input logic odd);
        @(posedge clk_sys_i);
        done_o <= 1'b1;
        status_o <= {ep, tx, odd};
        @(posedge clk_sys_i);
        done_o <= 1'b0;
        status_o <= ~{ep, tx, odd};
    endtask
    task automatic send_setup();
        @(posedge clk_sys_i);
        setup_o <= 1'b1;
        @(posedge clk_sys_i);
        setup_o <= 1'b0;
    endtask
    task automatic send_sof(input logic [10:0] f);
        @(posedge clk_sys_i);
        sof_o <= 1'b1;
        frame_o <= f;
        @(posedge clk_sys_i);
        sof_o <= 1'b0;
        frame_o <= ~f;
    endtask
    // Each launched token ends in one finished transaction, banks alternating.
    always begin
        @(posedge clk_sys_i iff token_start_i);
        repeat (answer_delay) @(posedge clk_sys_i);
        send_done(launch_i.token.endpoint, launch_i.token.pid != 4'h9, odd_bank);
        odd_bank = ~odd_bank;
    end
endmodule // uocs_link_model
`default_nettype wire

/* testbench/tb_top.sv */
// Self-checking bench for the USB control register block.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    // ****************************************
    // Bench
    // ****************************************
    localparam int FRAME = 20;
    logic clk_sys_i = 1'b0;
    logic rstn_i = 1'b0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [3:0] adr = 4'h0;
    logic [3:0] be = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic [31:0] r;
    logic [7:0] thr, buffer_descriptor_table;
    logic [10:0] sfrm;
    logic wreq, j, se0, xdone, setup, sof, lact, brst, rsm, eop, ppc, mon, hrst, hold, tst, fss, eof;
    logic odd = 1'b0;
    logic [3:0] pids [3] = '{4'h1, 4'h9, 4'hD};
    uocs_pkg::uocs_xact_t xst;
    uocs_pkg::uocs_launch_t tl;
    int err_count = 0;
    int num_checks = 0;
    int cyc = 0;
    int eop_cnt = 0;
    int sof_cnt = 0;
    int e;
    always #12.5 clk_sys_i = ~clk_sys_i;
    uocs_regs #(.FRAME_CYCLES(FRAME), .QUEUE_DEPTH(4)) i_dut (
        .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .avs_address_i(adr), .avs_read_i(rd),
        .avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(be),
        .avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .live_j_line_i(j),
        .live_se0_i(se0), .xact_done_i(xdone), .xact_status_i(xst), .setup_rx_i(setup),
        .sof_rx_i(sof), .sof_frame_i(sfrm), .link_active_i(lact), .bus_reset_drive_o(brst),
        .resume_drive_o(rsm), .resume_eop_o(eop), .pingpong_pointer_clear_o(ppc),
        .module_on_o(mon), .host_logic_reset_o(hrst), .packet_hold_o(hold),
        .token_start_o(tst), .token_launch_o(tl), .frame_start_send_o(fss),
        .eof_error_o(eof), .frame_start_threshold_o(thr), .descriptor_table_base_o(buffer_descriptor_table));
    uocs_link_model i_link (.clk_sys_i(clk_sys_i), .token_start_i(tst), .launch_i(tl),
        .live_j_o(j), .live_se0_o(se0), .done_o(xdone), .status_o(xst), .setup_o(setup),
        .sof_o(sof), .frame_o(sfrm), .active_o(lact));
    task automatic give_verdict();
        if (err_count == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] s);
        num_checks++;
        if (s !== x) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", n, x, s);
        end
    endtask
    // The request stays up until waitrequest is seen low at a rising edge.
    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d, input logic [3:0] b);
        @(posedge clk_sys_i);
        rd <= ~w;
        wr <= w;
        adr <= a;
        wdat <= {24'h0, d};
        be <= b;
        @(posedge clk_sys_i);
        while (wreq !== 1'b0) @(posedge clk_sys_i);
        r = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic wrr(input logic [3:0] a, input logic [7:0] d);
        bus(1'b1, a, d, 4'hF);
    endtask
    task automatic rdc(input string n, input logic [3:0] a, input logic [7:0] x);
        bus(1'b0, a, 8'h00, 4'hF);
        chk(n, {24'h0, x}, r);
    endtask
    always @(posedge clk_sys_i) begin
        cyc++;
        eop_cnt += eop;
        sof_cnt += fss;
        if (cyc == 4000) begin
            err_count++;
            give_verdict();
        end
    end
    initial begin
        repeat (12) @(posedge clk_sys_i);
        rstn_i <= 1'b1;
        for (int i = 0; i < 8; i++) rdc("reset value", i[3:0], 8'h00);
        wrr(4'h9, 8'h5A);
        rdc("unmapped", 4'h9, 8'h00);
        wrr(4'h2, 8'hC5);
        bus(1'b1, 4'h2, 8'h11, 4'h0);
        rdc("device address", 4'h2, 8'hC5);
        i_link.live_j_o <= 1'b1;
        wrr(4'h1, 8'h03);
        rdc("control", 4'h1, 8'h83);
        chk("pingpong clear", 1, ppc);
        chk("module on", 1, mon);
        i_link.live_j_o <= 1'b0;
        i_link.live_se0_o <= 1'b1;
        wrr(4'h1, 8'h01);
        rdc("control se0", 4'h1, 8'h41);
        chk("pingpong clear", 0, ppc);
        i_link.live_j_o <= 1'b1;
        i_link.live_se0_o <= 1'b0;
        i_link.send_setup();
        rdc("packet hold", 4'h1, 8'hA1);
        chk("packet hold out", 1, hold);
        wrr(4'h1, 8'h01);
        rdc("hold cleared", 4'h1, 8'h81);
        for (int i = 1; i < 6; i++) i_link.send_done(i[3:0], i[0], i[1]);
        rdc("done flag", 4'h8, 8'h08);
        for (int i = 1; i < 5; i++) begin
            rdc("status head", 4'h0, {i[3:0], i[0], i[1], 2'b00});
            wrr(4'h8, 8'h08);
        end
        rdc("queue empty", 4'h8, 8'h00);
        rdc("status empty", 4'h0, 8'h00);
        i_link.send_sof(11'h5A3);
        rdc("frame low", 4'h3, 8'hA3);
        rdc("frame high", 4'h4, 8'h05);
        wrr(4'h6, 8'h4A);
        rdc("threshold", 4'h6, 8'h4A);
        chk("threshold out", 8'h4A, thr);
        wrr(4'h7, 8'hFF);
        rdc("descriptor page", 4'h7, 8'hFE);
        chk("descriptor page out", 8'hFE, buffer_descriptor_table);
        wrr(4'h1, 8'h08);
        @(posedge clk_sys_i);
        chk("host logic reset", 1, hrst);
        rdc("host mode", 4'h1, 8'h88);
        chk("module off in host", 0, mon);
        wrr(4'h2, 8'h85);
        foreach (pids[k]) begin
            wrr(4'h5, {pids[k], 4'h3});
            rdc("token busy", 4'h1, 8'hA8);
            chk("launch", {7'h05, 1'b1, pids[k], 4'h3}, tl);
            r = 32'h20;
            while (r[5]) bus(1'b0, 4'h1, 8'h00, 4'hF);
            rdc("token status", 4'h0, {4'h3, pids[k] != 4'h9, odd, 2'b00});
            odd = ~odd;
            wrr(4'h8, 8'h08);
        end
        wrr(4'h5, 8'h23);
        rdc("reserved token idle", 4'h1, 8'h88);
        wrr(4'h1, 8'h18);
        rdc("reset drive", 4'h1, 8'h98);
        chk("bus reset", 1, brst);
        wrr(4'h1, 8'h08);
        // The output follows the control bit one edge after the write lands.
        repeat (2) @(posedge clk_sys_i);
        chk("bus reset end", 0, brst);
        // Resume is held far shorter than on a real bus to keep the run short.
        wrr(4'h1, 8'h0C);
        repeat (40) @(posedge clk_sys_i);
        chk("resume drive", 1, rsm);
        e = eop_cnt;
        wrr(4'h1, 8'h08);
        repeat (4) @(posedge clk_sys_i);
        chk("resume eop", 1, eop_cnt - e);
        i_link.active_o <= 1'b1;
        wrr(4'h1, 8'h09);
        repeat (10) @(posedge clk_sys_i);
        e = sof_cnt;
        repeat (5 * FRAME) @(posedge clk_sys_i);
        chk("frame starts", 5, sof_cnt - e);
        i_link.active_o <= 1'b0;
        rdc("eof error", 4'h8, 8'h02);
        wrr(4'h8, 8'h02);
        rdc("eof cleared", 4'h8, 8'h00);
        wrr(4'h1, 8'h08);
        repeat (2) @(posedge clk_sys_i);
        e = sof_cnt;
        repeat (3 * FRAME) @(posedge clk_sys_i);
        chk("no frame starts", 0, sof_cnt - e);
        give_verdict();
    end
endmodule // tb_top
`default_nettype wire
